// file: design/tcm_out_unit.sv
// Purpose: Holds the compare output state and applies match actions.
// Assumes: Events arrive as one-cycle pulses from the timer core.
// Notes: Action is read live, so a new value acts on the next event.
`timescale 1ns/100ps
`default_nettype none
module tcm_out_unit (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Events from the core.
  tcm_wave_if.unit wave
);
  import tcm_pkg::*;

  logic next_state;
  wire  non_pwm = (wave.cls == CLS_NORMAL) || (wave.cls == CLS_CTC) || (wave.cls == CLS_RSVD);
  wire  dual    = (wave.cls == CLS_PHASE) || (wave.cls == CLS_PFC);

  // Mode changes alone never touch the state; only events do.
  always_comb begin
    next_state = wave.state; // RQ4 RQ9
    if (non_pwm && (wave.match || wave.force_fire)) begin // RQ10
      case (wave.action) // RQ12 RQ5
        ACT_TOGGLE: next_state = ~wave.state;
        ACT_CLEAR:  next_state = 1'b0;
        ACT_SET:    next_state = 1'b1;
        default:    next_state = wave.state;
      endcase
    end else if (wave.cls == CLS_FAST && wave.wrap) begin
      if (wave.action == ACT_CLEAR) next_state = 1'b1; // RQ12
      else if (wave.action == ACT_SET) next_state = 1'b0;
    end else if (!non_pwm && wave.match) begin
      if (wave.action == ACT_CLEAR) next_state = dual && wave.down; // RQ12
      else if (wave.action == ACT_SET) next_state = !(dual && wave.down);
    end
  end

  // State register, cleared by reset whatever the pin shows.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) wave.state <= 1'b0; // RQ6
    else wave.state <= next_state;
  end

  chk_none_hold: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
    wave.action == ACT_NONE |=> $stable(wave.state)) else $error("output changed with no action");
  chk_force_set: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
    wave.force_fire && non_pwm && wave.action == ACT_SET |=> wave.state) else $error("force set lost");
  chk_mode_keep: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
    !wave.match && !wave.force_fire && !wave.wrap |=> $stable(wave.state)) else $error("state moved without event");

endmodule // tcm_out_unit
`default_nettype wire

// file: design/tcm_pkg.sv
// Purpose: Shared constants and types of the timer compare and mode block.
// Assumes: 32-bit AHB-Lite register access, one compare output channel.
// Notes: Register offsets are byte addresses of aligned words.
//
// Notes on behaviour
// RQ1 - Counter write blocks matches next timer cycle.
// RQ2 - Variable top written equal: run on to 0xffff.
// RQ3 - Software avoids writing count equal compare/bottom.
// RQ4 - Output state survives any mode change.
// RQ5 - Action field acts at first match after write.
// RQ6 - Reset clears output state to zero.
// RQ7 - Nonzero action drives pin from output state.
// RQ8 - Action field never touches capture register.
// RQ9 - Action zero leaves output state unchanged.
// RQ10 - Force strobe applies action now, non-PWM only.
// RQ11 - Only mode code shapes the counting sequence.
// RQ12 - PWM: invert select; otherwise set/clear/toggle.
// RQ13 - Decode mode code into class and top.
// RQ14 - Phase correct: buffer at top, overflow at bottom.
// RQ15 - Normal mode counts up, wraps to zero.
// RQ16 - Normal overflow flag set when count becomes zero.
// RQ17 - Normal mode accepts counter writes any time.
// RQ18 - Software presets output before enabling pin.
// RQ19 - Fast PWM copies compare A buffer at top.
// RQ20 - Fast PWM sets overflow at every top.
// RQ21 - Freq correct at bottom; normal/CLEAR_ON_MATCH_MODE update immediately.
package tcm_pkg;

  localparam int unsigned CNT_W = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FORCE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP   = 8'h0c;
  localparam logic [7:0] OFS_CMPA  = 8'h10;
  localparam logic [7:0] OFS_CAPT  = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_ACT   = 8'h1c;

  // Counter landmarks and fixed tops.
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
  localparam logic [CNT_W-1:0] TOP_8      = 16'h00ff;
  localparam logic [CNT_W-1:0] TOP_9      = 16'h01ff;
  localparam logic [CNT_W-1:0] TOP_10     = 16'h03ff;

  // Compare output action codes.
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // Control register layout, low bit first from the bottom of the struct.
  typedef struct packed {
    logic       run;
    logic       port_latch;
    logic       pin_direction;
    logic [1:0] action;
    logic [3:0] mode;
  } tcm_ctrl_t;
  localparam int unsigned CTRL_W = $bits(tcm_ctrl_t);

  // Status register layout; flags clear by writing one.
  typedef struct packed {
    logic down;
    logic out_state;
    logic match;
    logic overflow;
  } tcm_stat_t;
  localparam int unsigned STAT_W = $bits(tcm_stat_t);

  typedef enum logic [2:0] {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_PHASE, CLS_PFC, CLS_RSVD} tcm_class_t;
  typedef enum logic [2:0] {TS_MAX, TS_FIX8, TS_FIX9, TS_FIX10, TS_CAPT, TS_CMPA} tcm_topsrc_t;

  // Operating class of a mode code.
  function automatic tcm_class_t mode_class(input logic [3:0] m);
    case (m)
      4'h0: mode_class = CLS_NORMAL;
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: mode_class = CLS_PHASE;
      4'h4, 4'hc: mode_class = CLS_CTC;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_class = CLS_FAST;
      4'h8, 4'h9: mode_class = CLS_PFC;
      default: mode_class = CLS_RSVD;
    endcase
  endfunction

  // Source of the top value of a mode code.
  function automatic tcm_topsrc_t mode_top(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: mode_top = TS_FIX8;
      4'h2, 4'h6: mode_top = TS_FIX9;
      4'h3, 4'h7: mode_top = TS_FIX10;
      4'h8, 4'ha, 4'hc, 4'he: mode_top = TS_CAPT;
      4'h4, 4'h9, 4'hb, 4'hf: mode_top = TS_CMPA;
      default: mode_top = TS_MAX;
    endcase
  endfunction

endpackage

// file: design/tcm_top.sv
// Purpose: 16-bit timer core with waveform modes and compare output.
// Assumes: One timer clock cycle per system clock while run is set.
// Notes: Registers are reached over AHB-Lite with zero wait states.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tcm_top (
  // Clock and reset.
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  // AHB-Lite slave.
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // Compare pin and overflow flag.
  output logic             COMPARE_PIN_OUT,
  output logic             COMPARE_PIN_OE_OUT,
  output logic             OVERFLOW_FLAG_OUT
);
  import tcm_pkg::*;

  // Software visible state.
  tcm_ctrl_t          ctrl;
  logic [CNT_W-1:0]   counter_value;
  logic [CNT_W-1:0]   compare_value;
  logic [CNT_W-1:0]   compare_active;
  logic [CNT_W-1:0]   compare_a_value;
  logic [CNT_W-1:0]   compare_a_active;
  logic [CNT_W-1:0]   capture_register;
  logic               overflow_flag;
  logic               match_flag;
  logic               count_down;
  logic               match_block;

  // Bus data phase tracking.
  logic               wr_pend;
  logic [7:0]         wr_addr;
  logic [31:0]        next_rdata;

  // Counter next values.
  logic [CNT_W-1:0]   next_count;
  logic               next_down;
  logic               buf_load;
  logic               ovf_set;

  tcm_wave_if wave ();

  // Address phase accepted when the bus is ready and a transfer is live.
  wire addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire rd_ok   = addr_ok && !HWRITE_IN;

  // Write strobes for the data phase; HSIZE is not checked, words only.
  wire we_ctrl  = wr_pend && (wr_addr == OFS_CTRL);
  wire we_force = wr_pend && (wr_addr == OFS_FORCE);
  wire we_count = wr_pend && (wr_addr == OFS_COUNT);
  wire we_cmp   = wr_pend && (wr_addr == OFS_CMP);
  wire we_cmpa  = wr_pend && (wr_addr == OFS_CMPA);
  wire we_capt  = wr_pend && (wr_addr == OFS_CAPT);
  wire we_stat  = wr_pend && (wr_addr == OFS_STAT);

  wire [CNT_W-1:0] wr_word  = HWDATA_IN[CNT_W-1:0];
  wire tcm_stat_t  wr_clear = tcm_stat_t'(HWDATA_IN[STAT_W-1:0]);

  // Mode decode: class and top depend only on the mode code.
  wire tcm_class_t  cls  = mode_class(ctrl.mode); // RQ13 RQ11
  wire tcm_topsrc_t tsrc = mode_top(ctrl.mode); // RQ13
  wire pwm = (cls == CLS_FAST) || (cls == CLS_PHASE) || (cls == CLS_PFC);

  // Top value for the present mode.
  wire [CNT_W-1:0] top_value =
    (tsrc == TS_FIX8)  ? TOP_8 :
    (tsrc == TS_FIX9)  ? TOP_9 :
    (tsrc == TS_FIX10) ? TOP_10 :
    (tsrc == TS_CAPT)  ? capture_register :
    (tsrc == TS_CMPA)  ? compare_a_active : CNT_MAX; // RQ13

  // Match detection; a recent counter write hides top, compare and bottom matches.
  wire tick    = ctrl.run;
  wire at_top  = (counter_value == top_value);
  wire top_hit = tick && !match_block && at_top; // RQ1 RQ2
  wire cmp_hit = tick && !match_block && (counter_value == compare_active); // RQ1
  wire bot_hit = tick && !match_block && count_down && (counter_value == CNT_BOTTOM); // RQ1

  // Counting sequence per class; the action field is not an input here.
  always_comb begin
    next_count = counter_value;
    next_down  = (cls == CLS_PHASE || cls == CLS_PFC) ? count_down : 1'b0; // RQ11
    buf_load   = 1'b0;
    ovf_set    = 1'b0;
    if (tick) begin
      case (cls)
        CLS_FAST: begin
          if (top_hit) begin
            next_count = CNT_BOTTOM;
            ovf_set    = 1'b1; // RQ20
            buf_load   = 1'b1; // RQ19
          end else begin
            next_count = counter_value + CNT_ONE; // RQ2
          end
        end
        CLS_CTC: begin
          next_count = top_hit ? CNT_BOTTOM : counter_value + CNT_ONE;
          ovf_set    = !top_hit && (counter_value == CNT_MAX); // RQ21
        end
        CLS_PHASE, CLS_PFC: begin
          if (!count_down && top_hit) begin
            next_down  = 1'b1;
            next_count = counter_value - CNT_ONE;
            buf_load   = (cls == CLS_PHASE); // RQ14
          end else if (bot_hit) begin
            next_down  = 1'b0;
            next_count = counter_value + CNT_ONE;
            ovf_set    = 1'b1; // RQ14 RQ21
            buf_load   = (cls == CLS_PFC); // RQ21
          end else if (count_down) begin
            next_count = counter_value - CNT_ONE;
          end else begin
            next_count = counter_value + CNT_ONE;
          end
        end
        default: begin
          next_count = counter_value + CNT_ONE; // RQ15
          ovf_set    = (counter_value == CNT_MAX); // RQ16
        end
      endcase
    end
    // A software write always wins, in every mode and whether running or not.
    if (we_count) next_count = wr_word; // RQ17
  end

  // Read data mux, sampled in the address phase.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (HADDR_IN[7:0] == OFS_CTRL) begin
      next_rdata[CTRL_W-1:0] = ctrl;
    end else if (HADDR_IN[7:0] == OFS_COUNT) begin
      next_rdata[CNT_W-1:0] = counter_value;
    end else if (HADDR_IN[7:0] == OFS_CMP) begin
      next_rdata[CNT_W-1:0] = compare_value;
    end else if (HADDR_IN[7:0] == OFS_CMPA) begin
      next_rdata[CNT_W-1:0] = compare_a_value;
    end else if (HADDR_IN[7:0] == OFS_CAPT) begin
      next_rdata[CNT_W-1:0] = capture_register;
    end else if (HADDR_IN[7:0] == OFS_STAT) begin
      next_rdata[STAT_W-1:0] = {count_down, wave.state, match_flag, overflow_flag};
    end else if (HADDR_IN[7:0] == OFS_ACT) begin
      next_rdata[CNT_W-1:0] = compare_active;
    end
  end

  // Bus handshake registers; the slave never stalls and always answers OKAY.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_pend       <= 1'b0;
      wr_addr       <= 8'h00;
      HRDATA_OUT    <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      wr_pend       <= addr_ok && HWRITE_IN;
      wr_addr       <= addr_ok ? HADDR_IN[7:0] : wr_addr;
      HRDATA_OUT    <= rd_ok ? next_rdata : 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  // Control register and capture register; only the bus writes capture.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl             <= '0;
      capture_register <= CNT_BOTTOM;
    end else begin
      ctrl             <= we_ctrl ? tcm_ctrl_t'(HWDATA_IN[CTRL_W-1:0]) : ctrl;
      capture_register <= we_capt ? wr_word : capture_register; // RQ8
    end
  end

  // Counter, direction and the one-timer-cycle match block.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      counter_value <= CNT_BOTTOM;
      count_down    <= 1'b0;
      match_block   <= 1'b0;
    end else begin
      counter_value <= next_count;
      count_down    <= next_down;
      match_block   <= we_count || (match_block && !tick); // RQ1
    end
  end

  // Compare buffers: direct in non-PWM modes, copied at update points in PWM.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      compare_value    <= CNT_BOTTOM;
      compare_active   <= CNT_BOTTOM;
      compare_a_value  <= CNT_BOTTOM;
      compare_a_active <= CNT_BOTTOM;
    end else begin
      compare_value    <= we_cmp ? wr_word : compare_value;
      compare_a_value  <= we_cmpa ? wr_word : compare_a_value;
      compare_active   <= (!pwm && we_cmp) ? wr_word : (buf_load ? compare_value : compare_active); // RQ21 RQ14
      compare_a_active <= (!pwm && we_cmpa) ? wr_word : (buf_load ? compare_a_value : compare_a_active); // RQ19
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      overflow_flag <= 1'b0;
      match_flag    <= 1'b0;
    end else begin
      overflow_flag <= ovf_set || (overflow_flag && !(we_stat && wr_clear.overflow)); // RQ16
      match_flag    <= cmp_hit || (match_flag && !(we_stat && wr_clear.match));
    end
  end

  // Events to the output unit; forcing is ignored in PWM modes.
  assign wave.match      = cmp_hit;
  assign wave.force_fire = we_force && HWDATA_IN[0] && !pwm; // RQ10
  assign wave.wrap       = (cls == CLS_FAST) && top_hit;
  assign wave.down       = count_down;
  assign wave.cls        = cls;
  assign wave.action     = ctrl.action; // RQ5

  tcm_out_unit u_out (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .wave   (wave.unit)
  );

  // Pin drivers are registered, so the pin trails the state by one cycle.
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      COMPARE_PIN_OUT    <= 1'b0;
      COMPARE_PIN_OE_OUT <= 1'b0;
      OVERFLOW_FLAG_OUT  <= 1'b0;
    end else begin
      COMPARE_PIN_OUT    <= (ctrl.action != ACT_NONE) ? wave.state : ctrl.port_latch; // RQ7
      COMPARE_PIN_OE_OUT <= ctrl.pin_direction; // RQ7
      OVERFLOW_FLAG_OUT  <= overflow_flag;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  chk_write_blocks: assert property ( // RQ1
    $past(we_count) |-> !cmp_hit && !top_hit) else $error("match seen after counter write");
  chk_normal_wrap: assert property ( // RQ15 RQ16
    cls == CLS_NORMAL && tick && !we_count && counter_value == CNT_MAX
    |=> counter_value == CNT_BOTTOM && overflow_flag) else $error("normal wrap wrong");
  chk_ovf_sticky: assert property ( // RQ16
    overflow_flag && !we_stat |=> overflow_flag) else $error("overflow flag dropped");
  chk_fast_top: assert property ( // RQ20
    cls == CLS_FAST && top_hit && !we_count |=> counter_value == CNT_BOTTOM && overflow_flag)
    else $error("fast top not handled");
  chk_fast_abuf: assert property ( // RQ19
    cls == CLS_FAST && top_hit && !we_cmpa |=> compare_a_active == $past(compare_a_value))
    else $error("compare A buffer not copied");
  chk_phase_buf: assert property ( // RQ14
    cls == CLS_PHASE && !count_down && top_hit && !we_cmp |=> compare_active == $past(compare_value))
    else $error("phase buffer not copied at top");
  chk_phase_bot: assert property ( // RQ14
    cls == CLS_PHASE && bot_hit && !we_count |=> overflow_flag && !count_down)
    else $error("phase bottom not handled");
  chk_var_skip: assert property ( // RQ2
    cls == CLS_FAST && match_block && tick && !we_count && counter_value != CNT_MAX
    |=> counter_value == $past(counter_value) + CNT_ONE) else $error("blocked top cleared counter");
  chk_pin_source: assert property ( // RQ7
    ctrl.action != ACT_NONE |=> COMPARE_PIN_OUT == $past(wave.state))
    else $error("pin not from output state");

  // Compare buffers: straight through in non-PWM modes, held until the update point otherwise.
  chk_cmp_direct: assert property ( // RQ21
    !pwm && we_cmp |=> compare_active == $past(wr_word))
    else $error("direct compare write lost");
  chk_cmp_held: assert property ( // RQ14 RQ19
    pwm && we_cmp && !buf_load |=> compare_active == $past(compare_active))
    else $error("buffered compare changed early");
  chk_pfc_bottom: assert property ( // RQ21
    cls == CLS_PFC && bot_hit && !we_count |=> overflow_flag && compare_active == $past(compare_value))
    else $error("freq correct bottom wrong");

  // Counting per class; a slip here would move every waveform edge.
  chk_normal_step: assert property ( // RQ15
    cls == CLS_NORMAL && tick && !we_count && counter_value != CNT_MAX
    |=> counter_value == $past(counter_value) + CNT_ONE) else $error("normal count skipped");
  chk_ctc_clear: assert property ( // RQ13 RQ21
    cls == CLS_CTC && top_hit && !we_count |=> counter_value == CNT_BOTTOM)
    else $error("clear on match missed");
  chk_dual_ovf: assert property ( // RQ14 RQ21
    (cls == CLS_PHASE || cls == CLS_PFC) && !bot_hit && !overflow_flag |=> !overflow_flag)
    else $error("dual slope overflow off bottom");

  // A blocked match must not reach the sticky flag either.
  chk_block_flag: assert property ( // RQ1
    match_block && tick && !match_flag |=> !match_flag)
    else $error("blocked match set flag");

endmodule // tcm_top
`default_nettype wire

// file: design/tcm_wave_if.sv
// Purpose: Carries match events and settings to the output unit.
// Assumes: All signals live in the system clock domain.
// Notes: The core drives events, the unit returns the output state.
`timescale 1ns/100ps
`default_nettype none
interface tcm_wave_if;
  import tcm_pkg::*;
  logic       match;
  logic       force_fire;
  logic       wrap;
  logic       down;
  tcm_class_t cls;
  logic [1:0] action;
  logic       state;
  modport core (output match, force_fire, wrap, down, cls, action, input state);
  modport unit (input match, force_fire, wrap, down, cls, action, output state);
endinterface
`default_nettype wire

// file: testbench/tb_tcm_top.sv
// Purpose: Self-checking bench for the timer compare and mode block.
// Assumes: Zero-wait AHB-Lite slave, one timer tick per clock while running.
// Notes: Expectations come from the mode table and the output actions.
`timescale 1ns/100ps
`default_nettype none
module tb_tcm_top;
  import tcm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         pin;
  wire         pin_oe;
  wire         ovf;
  int          fails = 0;
  int          checked = 0;

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // The single slave's ready is the bus ready.
  tcm_top tcm_top_inst (
    .SYS_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .COMPARE_PIN_OUT(pin), .COMPARE_PIN_OE_OUT(pin_oe), .OVERFLOW_FLAG_OUT(ovf)
  );

  // Compares one value; four-state equality keeps unknowns from passing.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single transfer; each phase holds until hready is sampled high.
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr_en;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 32);
    rd = hrdata;
    check(32'(n < 32), 32'h1, "bus answer");
  endtask

  // Thin wrappers for writes and checked reads.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  task automatic stat_bit(input int b, input logic e, input string what);
    xfer(1'b0, OFS_STAT, 32'h0);
    check(32'(rd[b]), 32'(e), what);
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] ac, input logic dir,
                                      input logic lat, input logic run);
    return {23'h0, run, lat, dir, ac, m};
  endfunction

  // Waits a bounded time for the overflow output to rise.
  task automatic wait_ovf(input int lim);
    int n = 0;
    while (ovf !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(32'(ovf), 32'h1, "overflow flag");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Stops the timer, loads the counter and clears both flags.
  task automatic prep(input logic [3:0] m, input logic [1:0] ac, input logic [15:0] cnt);
    wr(OFS_CTRL, ctl(m, ac, 1'b0, 1'b0, 1'b0));
    wr(OFS_COUNT, {16'h0, cnt});
    wr(OFS_STAT, 32'h3);
  endtask

  task automatic t_reset();
    rdchk(OFS_CTRL, 32'h0, "ctrl reset");
    rdchk(OFS_COUNT, 32'h0, "count reset");
    rdchk(OFS_STAT, 32'h0, "stat reset");
    check(32'(pin), 32'h0, "pin reset");
    check(32'(hresp), 32'h0, "okay response");
    wr(8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h0, "unmapped read");
  endtask

  // Force strobe walks every action code while the pin is still an input.
  task automatic t_force();
    logic [1:0] acts [5] = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE, ACT_CLEAR};
    logic       exps [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, ctl(4'h0, acts[i], 1'b0, 1'b0, 1'b0));
      wr(OFS_FORCE, 32'h1);
      stat_bit(2, exps[i], "forced state");
    end
    wr(OFS_CTRL, ctl(4'h0, ACT_SET, 1'b1, 1'b0, 1'b0));
    wr(OFS_FORCE, 32'h1);
    idle(4);
    check(32'(pin), 32'h1, "pin from state");
    check(32'(pin_oe), 32'h1, "pin enable");
    wr(OFS_CTRL, ctl(4'h0, ACT_NONE, 1'b1, 1'b0, 1'b0));
    idle(4);
    check(32'(pin), 32'h0, "pin from latch");
    wr(OFS_CTRL, ctl(4'h5, ACT_CLEAR, 1'b0, 1'b0, 1'b0));
    wr(OFS_FORCE, 32'h1);
    stat_bit(2, 1'b1, "force ignored in pwm");
  endtask

  // Every mode code and action change must leave state and capture alone.
  task automatic t_keep();
    wr(OFS_CAPT, 32'h0000_1234);
    for (int m = 0; m < 16; m++) begin
      wr(OFS_CTRL, ctl(4'(m), 2'(m), 1'b0, 1'b0, 1'b0));
      stat_bit(2, 1'b1, "state across mode");
    end
    rdchk(OFS_CAPT, 32'h0000_1234, "capture untouched");
  endtask

  // A counter write equal to the compare value hides that match.
  task automatic t_block();
    prep(4'h0, ACT_TOGGLE, 16'h0010);
    wr(OFS_CMP, 32'h0000_0010);
    wr(OFS_CTRL, ctl(4'h0, ACT_TOGGLE, 1'b0, 1'b0, 1'b1));
    idle(8);
    wr(OFS_CTRL, ctl(4'h0, ACT_TOGGLE, 1'b0, 1'b0, 1'b0));
    stat_bit(1, 1'b0, "blocked match flag");
    stat_bit(2, 1'b1, "blocked state");
    prep(4'h0, ACT_TOGGLE, 16'h000f);
    wr(OFS_CTRL, ctl(4'h0, ACT_TOGGLE, 1'b0, 1'b0, 1'b1));
    idle(8);
    wr(OFS_CTRL, ctl(4'h0, ACT_TOGGLE, 1'b0, 1'b0, 1'b0));
    stat_bit(1, 1'b1, "match flag");
    stat_bit(2, 1'b0, "toggled state");
  endtask

  task automatic t_normal();
    prep(4'h0, ACT_SET, 16'hfff0);
    wr(OFS_CTRL, ctl(4'h0, ACT_SET, 1'b0, 1'b0, 1'b1));
    wait_ovf(64);
    wr(OFS_CTRL, ctl(4'h0, ACT_SET, 1'b0, 1'b0, 1'b0));
    xfer(1'b0, OFS_COUNT, 32'h0);
    check(rd & 32'hffff_ffe0, 32'h0, "wrapped count");
    stat_bit(0, 1'b1, "flag held");
  endtask

  // Compare writes are immediate in normal mode, buffered to top in fast mode.
  task automatic t_buffer();
    wr(OFS_CMP, 32'h0000_0040);
    rdchk(OFS_ACT, 32'h0000_0040, "immediate compare");
    prep(4'h5, ACT_CLEAR, 16'h0000);
    wr(OFS_CMP, 32'h0000_0080);
    rdchk(OFS_ACT, 32'h0000_0040, "held in buffer");
    wr(OFS_CTRL, ctl(4'h5, ACT_CLEAR, 1'b0, 1'b0, 1'b1));
    wait_ovf(300);
    wr(OFS_CTRL, ctl(4'h5, ACT_CLEAR, 1'b0, 1'b0, 1'b0));
    rdchk(OFS_ACT, 32'h0000_0080, "copied at top");
    xfer(1'b0, OFS_COUNT, 32'h0);
    check(rd & 32'hffff_ffe0, 32'h0, "fixed top wrap");
    stat_bit(2, 1'b1, "set at bottom");
  endtask

  // Phase correct turns at the fixed top and flags at the bottom.
  task automatic t_phase();
    prep(4'h1, ACT_CLEAR, 16'h0000);
    wr(OFS_CMP, 32'h0000_0020);
    wr(OFS_CTRL, ctl(4'h1, ACT_CLEAR, 1'b0, 1'b0, 1'b1));
    idle(300);
    stat_bit(0, 1'b0, "no flag at top");
    stat_bit(3, 1'b1, "down slope");
    rdchk(OFS_ACT, 32'h0000_0020, "copied at top");
    stat_bit(2, 1'b0, "cleared on up match");
    wait_ovf(400);
    wr(OFS_CTRL, ctl(4'h1, ACT_CLEAR, 1'b0, 1'b0, 1'b0));
    stat_bit(2, 1'b1, "set on down match");
  endtask

  // Counter written equal to a variable top runs past it.
  task automatic t_vtop();
    wr(OFS_CAPT, 32'h0000_0020);
    prep(4'he, ACT_NONE, 16'h0020);
    wr(OFS_CTRL, ctl(4'he, ACT_NONE, 1'b0, 1'b0, 1'b1));
    idle(40);
    wr(OFS_CTRL, ctl(4'he, ACT_NONE, 1'b0, 1'b0, 1'b0));
    xfer(1'b0, OFS_COUNT, 32'h0);
    check(32'(rd >= 32'h40), 32'h1, "ran past top");
  endtask

  // Clear-on-match wraps at compare A; freq correct copies its buffer at bottom.
  task automatic t_ctc_pfc();
    prep(4'h4, ACT_NONE, 16'h0000);
    wr(OFS_CMPA, 32'h0000_0010);
    wr(OFS_CTRL, ctl(4'h4, ACT_NONE, 1'b0, 1'b0, 1'b1));
    idle(40);
    check(32'(ovf), 32'h0, "no overflow at top");
    xfer(1'b0, OFS_COUNT, 32'h0);
    check(32'(rd <= 32'h10), 32'h1, "cleared at top");
    prep(4'h8, ACT_NONE, 16'h0000);
    wr(OFS_CAPT, 32'h0000_0010);
    wr(OFS_CMP, 32'h0000_0008);
    wr(OFS_CTRL, ctl(4'h8, ACT_NONE, 1'b0, 1'b0, 1'b1));
    wait_ovf(80);
    prep(4'h8, ACT_NONE, 16'h0000);
    rdchk(OFS_ACT, 32'h0000_0008, "copied at bottom");
  endtask

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after 20 cycles of reset.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_force();
    t_keep();
    t_block();
    t_normal();
    t_buffer();
    t_phase();
    t_vtop();
    t_ctc_pfc();
    conclude();
  end

  // Watchdog well beyond the expected run of about 1200 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // tb_tcm_top
`default_nettype wire
